//--- hdl/link_pkg.sv
// shared constants for the link control/status attention block
package link_pkg;
   // apb byte addresses, one aligned word each
   localparam logic [7:0] LCS_ADDR  = 8'h00; // link control status
   localparam logic [7:0] STS_ADDR  = 8'h04; // sticky event status
   localparam logic [7:0] MASK_ADDR = 8'h08; // event mask
   localparam logic [7:0] CFG_ADDR  = 8'h0c; // link configuration
   // link control status bit positions
   localparam int B_GO    = 0;  // go, reads zero
   localparam int B_FNCT1 = 1;  // cycle type sent to companion
   localparam int B_FAR   = 2;  // far interrupt request out
   localparam int B_BURST = 3;  // burst/block select out
   localparam int B_IE    = 6;  // interrupt enable
   localparam int B_READY = 7;  // ready flag
   localparam int B_STC   = 9;  // companion cycle type
   localparam int B_STB   = 10; // companion far interrupt
   localparam int B_STA   = 11; // companion burst/block
   localparam int B_ATTENTION_FLAG  = 13; // attention flag
   localparam int B_ERR   = 15; // error flag
   // writable storage bits: 1..6 and 8
   localparam logic [15:0] LCS_WMASK = 16'h017e;
   localparam logic [15:0] LCS_RESET = 16'h0000;
   localparam logic        READY_RESET = 1'h1;
   // configuration register: bit 0 marks a mixed-type link
   localparam int B_MIXED = 0;
   // event bits of the sticky status and mask registers
   localparam int EV_ERR = 0;   // error while interrupts enabled
   localparam int EV_FAR = 1;   // companion interrupt request rose
   localparam int EV_PF  = 2;   // companion power fail rose
   localparam int NEV    = 3;
   localparam logic [2:0] MASK_RESET = 3'h7;
   // cable input count through the synchroniser
   localparam int NCABLE = 5;
endpackage : link_pkg

//--- hdl/cable_if.sv
// synchronised cable levels between synchroniser and core
`timescale 1ns/100ps
interface cable_if;
   logic cyc_type;   // companion cycle type level
   logic far_int;    // companion far interrupt request
   logic burst_sel;  // companion burst/block select
   logic power_fail; // companion power fail signal
   logic attention_flag_req;   // ordinary local attention cause
   modport sync_side (output cyc_type, far_int, burst_sel,
                      power_fail, attention_flag_req);
   modport core_side (input cyc_type, far_int, burst_sel,
                      power_fail, attention_flag_req);
endinterface : cable_if

//--- hdl/link_sync.sv
// three-stage synchroniser with agreement filter for cable pins
`timescale 1ns/100ps
module link_sync import link_pkg::*; #(
   parameter int W = NCABLE
) (
   input  wire logic         mclk,
   input  wire logic         reset_n,
   input  wire logic [W-1:0] raw,
   cable_if.sync_side        lk
);
   typedef struct packed {
      logic [W-1:0] s1; // first stage, read by s2 only
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] q;  // accepted level
   } sync_type;
   sync_type st, next_st;
   // a level counts only once stages two and three agree
   always_comb begin
      next_st = st;
      next_st.s1 = raw;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
      for (int i = 0; i < W; i++) begin
         if (st.s2[i] == st.s3[i]) next_st.q[i] = st.s3[i];
      end
   end
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) st <= '0;
      else          st <= next_st;
   end
   assign {lk.attention_flag_req, lk.power_fail, lk.burst_sel,
           lk.far_int, lk.cyc_type} = st.q;
   a_sync_agree: assert property (@(posedge mclk) disable iff (!reset_n)
      (st.s2 == st.s3) |=> (st.q == $past(st.s3)))
      else $error("accepted level missed agreeing stages");
endmodule : link_sync

//--- hdl/event_flags.sv
// sticky event status, mask and level interrupt
`timescale 1ns/100ps
module event_flags import link_pkg::*; #(
   parameter int N = NEV
) (
   input  wire logic         mclk,
   input  wire logic         reset_n,
   input  wire logic [N-1:0] set_ev,
   input  wire logic         clr_we,
   input  wire logic [N-1:0] clr_data,
   input  wire logic         mask_we,
   input  wire logic [N-1:0] mask_data,
   output logic      [N-1:0] status,
   output logic      [N-1:0] mask,
   output logic              irq
);
   typedef struct packed {
      logic [N-1:0] sts;
      logic [N-1:0] msk;
      logic         irq;
   } ev_type;
   ev_type st, next_st;
   // write one clears; a same-cycle event wins over the clear
   always_comb begin
      next_st = st;
      if (clr_we) next_st.sts = st.sts & ~clr_data;
      next_st.sts = next_st.sts | set_ev;
      if (mask_we) next_st.msk = mask_data;
      next_st.irq = |(next_st.sts & next_st.msk);
   end
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         st.sts <= '0;
         st.msk <= N'(MASK_RESET);
         st.irq <= 1'b0;
      end else begin
         st <= next_st;
      end
   end
   assign status = st.sts;
   assign mask   = st.msk;
   assign irq    = st.irq;
   a_event_irq: assert property (@(posedge mclk) disable iff (!reset_n)
      |(set_ev & st.msk) && !mask_we |=> irq)
      else $error("unmasked event did not raise interrupt");
endmodule : event_flags

//--- hdl/link_status_attention_bits.sv
// link control status register with companion status and attention
//
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/100ps
module link_status_attention_bits import link_pkg::*; (
   input  wire logic        mclk,
   input  wire logic        reset_n,
   // apb slave
   input  wire logic [7:0]  paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // cable from the companion board
   input  wire logic        companion_cycle_type,
   input  wire logic        companion_far_interrupt_request,
   input  wire logic        companion_burst_block_select,
   input  wire logic        companion_power_fail_signal,
   input  wire logic        attention_request,
   // cable toward the companion board
   output logic             cycle_type_out,
   output logic             far_interrupt_request,
   output logic             burst_block_select,
   output logic             burst_hold_request,
   // host interrupt
   output logic             host_irq
);

   ////////////////////////////////////////////////////////////////////
   // state

   typedef struct packed {
      logic [15:0] ctl;       // writable control storage
      logic        ready;     // ready flag
      logic        attention_flag;      // attention flag
      logic        err;       // error flag
      logic        mixed;     // mixed-type link configured
      logic        far_d;     // far request, previous cycle
      logic        pf_d;      // power fail, previous cycle
      logic        ar_d;      // local attention, previous cycle
      logic        pready;    // apb answer
      logic        pslverr;   // apb error answer
      logic [31:0] prdata;    // apb read data
      logic        fnct1;     // cycle type toward companion
      logic        far;       // far request toward companion
      logic        burst;     // burst/block toward companion
      logic        hold;      // burst hold request
   } core_type;

   core_type st, next_st;     // registered and next state

   cable_if lk ();            // synchronised cable levels

   logic [NEV-1:0] ev_set;    // event pulses into the flags
   logic [NEV-1:0] ev_status; // sticky status readback
   logic [NEV-1:0] ev_mask;   // mask readback
   logic           ev_clr_we; // status write strobe
   logic           ev_msk_we; // mask write strobe

   logic apb_req;             // access phase, answer not yet given
   logic apb_done;            // access phase completing this edge
   logic wr_lcs;              // completing write to control status
   logic wr_cfg;              // completing write to configuration
   logic far_rise;            // companion request became set
   logic pf_rise;             // companion power fail became set
   logic ar_rise;             // local attention cause became set
   logic set_any;             // any attention source this cycle
   logic clr_attention_flag;            // software clear allowed this cycle

   ////////////////////////////////////////////////////////////////////
   // helpers

   // address decode shared by the read and write paths
   function automatic logic is_addr(input logic [7:0] a,
                                    input logic [7:0] r);
      is_addr = (a == r);
   endfunction : is_addr

   // composes the control status word as software sees it
   function automatic logic [15:0] lcs_value(input core_type s,
                                             input logic c,
                                             input logic b,
                                             input logic a);
      logic [15:0] v;
      v = s.ctl & LCS_WMASK;
      v[B_READY] = s.ready;
      v[B_STC]   = c;
      v[B_STB]   = b;
      v[B_STA]   = a;
      v[B_ATTENTION_FLAG]  = s.attention_flag;
      v[B_ERR]   = s.err;
      lcs_value = v;
   endfunction : lcs_value

   ////////////////////////////////////////////////////////////////////
   // submodules

   // cable pins come from another machine: four flops each
   link_sync #(.W(NCABLE)) u_sync (
      .mclk    (mclk),
      .reset_n (reset_n),
      .raw     ({attention_request,
                 companion_power_fail_signal,
                 companion_burst_block_select,
                 companion_far_interrupt_request,
                 companion_cycle_type}),
      .lk      (lk.sync_side)
   );

   // sticky events gated by the mask onto the host interrupt
   event_flags #(.N(NEV)) u_flags (
      .mclk      (mclk),
      .reset_n   (reset_n),
      .set_ev    (ev_set),
      .clr_we    (ev_clr_we),
      .clr_data  (pwdata[NEV-1:0]),
      .mask_we   (ev_msk_we),
      .mask_data (pwdata[NEV-1:0]),
      .status    (ev_status),
      .mask      (ev_mask),
      .irq       (host_irq)
   );

   ////////////////////////////////////////////////////////////////////
   // bus strobes and edge detection

   // one wait state: answer on the second access-phase edge
   assign apb_req   = psel & penable & ~st.pready;
   assign apb_done  = psel & penable & st.pready;
   assign wr_lcs    = apb_done & pwrite & is_addr(paddr, LCS_ADDR);
   assign wr_cfg    = apb_done & pwrite & is_addr(paddr, CFG_ADDR);
   assign ev_clr_we = apb_done & pwrite & is_addr(paddr, STS_ADDR);
   assign ev_msk_we = apb_done & pwrite & is_addr(paddr, MASK_ADDR);

   // edges of the synchronised cable levels
   assign far_rise = lk.far_int & ~st.far_d;
   assign pf_rise  = lk.power_fail & ~st.pf_d;
   assign ar_rise  = lk.attention_flag_req & ~st.ar_d;

   // far request is a level source: it holds attention set
   assign set_any  = lk.far_int | pf_rise | ar_rise;

   // a zero in bit 13 clears, unless the companion still requests
   assign clr_attention_flag = wr_lcs & ~pwdata[B_ATTENTION_FLAG]
                     & ~lk.far_int;

   // events for the sticky status register
   always_comb begin
      ev_set         = '0;
      ev_set[EV_ERR] = st.err & st.ctl[B_IE];
      ev_set[EV_FAR] = far_rise;
      ev_set[EV_PF]  = pf_rise;
   end

   ////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      next_st = st;
      // edge history
      next_st.far_d = lk.far_int;
      next_st.pf_d  = lk.power_fail;
      next_st.ar_d  = lk.attention_flag_req;

      // software writes touch only the storage bits
      if (wr_lcs) begin
         next_st.ctl = pwdata[15:0] & LCS_WMASK;
      end
      if (wr_cfg) begin
         next_st.mixed = pwdata[B_MIXED];
      end

      // ready: go clears it, companion request sets it
      if (wr_lcs && pwdata[B_GO]) begin
         next_st.ready = 1'b0;
      end
      if (far_rise) begin
         next_st.ready = 1'b1;
      end

      // attention: set wins over the clear in the same cycle
      next_st.attention_flag = (st.attention_flag & ~clr_attention_flag) | set_any;
      // error forced by attention, cleared together with it
      next_st.err = ((st.err | st.attention_flag) & ~clr_attention_flag)
                    | set_any;

      // cable outputs follow the stored function bits
      next_st.fnct1 = next_st.ctl[B_FNCT1];
      next_st.far   = next_st.ctl[B_FAR];
      // a mixed link must see our select held cleared
      next_st.burst = next_st.ctl[B_BURST]
                      & ~next_st.mixed;
      // burst holding is not usable on a mixed link
      next_st.hold  = ~next_st.ctl[B_BURST]
                      & ~next_st.mixed;

      // apb answer and read data, loaded on the wait edge
      next_st.pready  = apb_req;
      next_st.pslverr = 1'b0;
      if (apb_req) begin
         next_st.prdata = '0;
         if (is_addr(paddr, LCS_ADDR)) begin
            next_st.prdata[15:0] = lcs_value(st, lk.cyc_type,
                                             lk.far_int,
                                             lk.burst_sel);
         end else if (is_addr(paddr, STS_ADDR)) begin
            next_st.prdata[NEV-1:0] = ev_status;
         end else if (is_addr(paddr, MASK_ADDR)) begin
            next_st.prdata[NEV-1:0] = ev_mask;
         end else if (is_addr(paddr, CFG_ADDR)) begin
            next_st.prdata[B_MIXED] = st.mixed;
         end else begin
            // unmapped: error answer, writes ignored
            next_st.pslverr = 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // state register

   // reset loads constants only; the far request, if still held,
   // re-sets attention a few cycles after release
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         st       <= '0;
         st.ctl   <= LCS_RESET;
         st.ready <= READY_RESET;
         st.hold  <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // outputs, all straight from flops

   assign prdata                = st.prdata;
   assign pready                = st.pready;
   assign pslverr               = st.pslverr;
   assign cycle_type_out        = st.fnct1;
   assign far_interrupt_request = st.far;
   assign burst_block_select    = st.burst;
   assign burst_hold_request    = st.hold;

   ////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!reset_n);

   // a completing read of the control status word
   sequence seq_rd_lcs;
      apb_done && !pwrite && is_addr(paddr, LCS_ADDR);
   endsequence

   // a completing write that clears burst select, link not mixed
   sequence seq_wr_burst_clr;
      wr_lcs && !pwdata[B_BURST] && !st.mixed && !wr_cfg;
   endsequence

   // a software clear with no new attention source pending
   sequence seq_clear_ok;
      clr_attention_flag && !set_any;
   endsequence

   a_status_read: assert property (
      seq_rd_lcs |-> prdata[B_STA:B_STC] ==
         $past({lk.burst_sel, lk.far_int, lk.cyc_type}))
      else $error("companion status bits read back wrong");

   a_far_ready: assert property (
      far_rise |=> st.ready && st.attention_flag ##1 ev_status[EV_FAR])
      else $error("companion request missed ready or attention");

   a_mixed_clear: assert property (
      st.mixed |-> !burst_block_select)
      else $error("burst select driven on a mixed link");

   a_attention_flag_err: assert property (
      st.attention_flag |-> st.err)
      else $error("attention set without error");

   a_clear_both: assert property (
      seq_clear_ok |=> !st.attention_flag && !st.err)
      else $error("software clear failed to clear flags");

   a_far_holds: assert property (
      lk.far_int |=> st.attention_flag && st.err)
      else $error("flags cleared while far request held");

   a_err_irq: assert property (
      st.err && st.ctl[B_IE] && ev_mask[EV_ERR] && !ev_msk_we
      |-> ##[1:2] host_irq)
      else $error("enabled error gave no host interrupt");

   a_burst_hold: assert property (
      seq_wr_burst_clr |=> burst_hold_request && !burst_block_select)
      else $error("burst hold not raised after clearing select");

   a_ro_status: assert property (
      wr_lcs |=> st.ctl[B_STA:B_STC] == 3'h0)
      else $error("companion status bits took a write");

   a_apb_answer: assert property (
      apb_req |=> pready ##1 !pready)
      else $error("apb answer not one cycle after access");

endmodule : link_status_attention_bits

//--- test/companion_model.sv
// behavioural model of the companion board at the far end of the cable
`timescale 1ns/100ps
module companion_model (
   input  wire logic mclk,
   input  wire logic want_cyc,   // companion cycle type to show
   input  wire logic want_far,   // companion far interrupt to raise
   input  wire logic want_burst, // companion burst/block choice
   input  wire logic want_pf,    // companion power failing
   input  wire logic mixed,      // companion is the other bus type
   input  wire logic hold_in,    // our burst hold request line
   output logic      cyc_out,    // cable: companion cycle type
   output logic      far_out,    // cable: companion far request
   output logic      burst_out,  // cable: companion burst/block
   output logic      pf_out,     // cable: companion power fail
   output logic      hold_seen   // what the companion sees of hold
);
   ////////////////////////////////////////////////////////////////////////
   // quiet cable at time zero, before the first edge
   initial begin
      cyc_out   = 1'h0;
      far_out   = 1'h0;
      burst_out = 1'h0;
      pf_out    = 1'h0;
      hold_seen = 1'h0;
   end
   // registered driver: levels move only just after an edge
   always @(posedge mclk) begin
      cyc_out   <= want_cyc;
      far_out   <= want_far;
      pf_out    <= want_pf;
      hold_seen <= hold_in;
      // other bus type forces our bit 11 whatever software asked
      burst_out <= mixed ? 1'h1 : want_burst;
   end
endmodule : companion_model

//--- test/link_status_attention_bits_test.sv
// self-checking bench for the link status and attention block
`timescale 1ns/100ps
module link_status_attention_bits_test import link_pkg::*; ;
   // expected register bits, built from the package positions
   localparam logic [31:0] RDY = 32'h1 << B_READY;
   localparam logic [31:0] IEN = 32'h1 << B_IE;
   localparam logic [31:0] STC = 32'h1 << B_STC;
   localparam logic [31:0] STB = 32'h1 << B_STB;
   localparam logic [31:0] STA = 32'h1 << B_STA;
   localparam logic [31:0] ATN = 32'h1 << B_ATTENTION_FLAG;
   localparam logic [31:0] ERF = 32'h1 << B_ERR;
   logic        mclk, reset_n;              // clock and reset
   logic [7:0]  paddr;                      // apb address
   logic        psel, penable, pwrite;      // apb control
   logic [31:0] pwdata, prdata;             // apb data
   logic        pready, pslverr;            // apb answer
   logic        w_cyc, w_far, w_burst, w_pf, mixed; // partner commands
   logic        c_cyc, c_far, c_burst, c_pf, hold_seen; // cable
   logic        attention_request;          // local attention cause
   logic        cyc_o, far_o, bsel_o, hold_o, host_irq; // outputs
   logic [31:0] q;                          // read result
   logic        e;                          // read error flag
   int          n_fail, checks, cycles;     // counters
   ////////////////////////////////////////////////////////////////////////
   link_status_attention_bits uut (
      .mclk(mclk), .reset_n(reset_n), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .companion_cycle_type(c_cyc),
      .companion_far_interrupt_request(c_far),
      .companion_burst_block_select(c_burst),
      .companion_power_fail_signal(c_pf),
      .attention_request(attention_request),
      .cycle_type_out(cyc_o), .far_interrupt_request(far_o),
      .burst_block_select(bsel_o), .burst_hold_request(hold_o),
      .host_irq(host_irq));
   companion_model peer (
      .mclk(mclk), .want_cyc(w_cyc), .want_far(w_far),
      .want_burst(w_burst), .want_pf(w_pf), .mixed(mixed),
      .hold_in(hold_o), .cyc_out(c_cyc), .far_out(c_far),
      .burst_out(c_burst), .pf_out(c_pf), .hold_seen(hold_seen));
   ////////////////////////////////////////////////////////////////////////
   // verdict, reached from the main sequence or the timeout
   task automatic results;
      $display("checks %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : results
   // one comparison, counted
   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                      input string what);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk
   // one apb transfer; waits for pready, then an idle edge
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      psel    <= 1'h1;
      penable <= 1'h0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge mclk);
      penable <= 1'h1;
      // slave latency is the design's business; a wait that never
      // sees pready is ended by the bench timeout alone
      do @(posedge mclk);
      while (pready !== 1'h1);
      q = prdata;
      e = pslverr;
      psel    <= 1'h0;
      penable <= 1'h0;
      @(posedge mclk);
   endtask : apb
   // long enough for the cable synchroniser and status
   task automatic settle;
      repeat (6) @(posedge mclk);
   endtask : settle
   ////////////////////////////////////////////////////////////////////////
   // reset values and an unmapped address
   task automatic t_reset;
      apb(1'h0, LCS_ADDR, 32'h0);
      chk(q, RDY, "lcs reset");
      chk(32'(e), 32'h0, "lcs no err");
      apb(1'h0, MASK_ADDR, 32'h0);
      chk(q, 32'(MASK_RESET), "mask reset");
      apb(1'h0, 8'h10, 32'h0);
      chk(32'(e), 32'h1, "unmapped err");
      chk(32'(hold_o), 32'h1, "hold reset");
      $display("test reset done");
   endtask : t_reset
   // companion status bits mirror the cable and ignore writes
   task automatic t_mirror;
      w_cyc   <= 1'h1;
      w_burst <= 1'h1;
      settle();
      apb(1'h1, LCS_ADDR, 32'h2000);
      apb(1'h0, LCS_ADDR, 32'h0);
      chk(q, RDY | STC | STA, "mirror set");
      w_cyc   <= 1'h0;
      w_burst <= 1'h0;
      settle();
      apb(1'h1, LCS_ADDR, 32'h2e00);
      apb(1'h0, LCS_ADDR, 32'h0);
      chk(q, RDY, "mirror clr");
      $display("test mirror done");
   endtask : t_mirror
   // far request sets flags and blocks clearing while held
   task automatic t_far;
      apb(1'h1, LCS_ADDR, 32'h0041);
      apb(1'h0, LCS_ADDR, 32'h0);
      chk(q, IEN, "go clears ready");
      w_far <= 1'h1;
      settle();
      apb(1'h0, LCS_ADDR, 32'h0);
      chk(q, IEN | RDY | STB | ATN | ERF, "far");
      apb(1'h0, STS_ADDR, 32'h0);
      chk(q, 32'h3, "far status");
      chk(32'(host_irq), 32'h1, "far irq");
      apb(1'h1, LCS_ADDR, 32'h0040);
      apb(1'h0, LCS_ADDR, 32'h0);
      chk(q, IEN | RDY | STB | ATN | ERF, "clr blocked");
      w_far <= 1'h0;
      settle();
      apb(1'h1, LCS_ADDR, 32'h0040);
      apb(1'h0, LCS_ADDR, 32'h0);
      chk(q, IEN | RDY, "clr works");
      apb(1'h1, STS_ADDR, 32'h7);
      repeat (3) @(posedge mclk);
      chk(32'(host_irq), 32'h0, "irq cleared");
      $display("test far done");
   endtask : t_far
   // power fail and local cause set attention; mask gates irq
   task automatic t_pf;
      apb(1'h1, LCS_ADDR, 32'h0);
      apb(1'h1, MASK_ADDR, 32'h3);
      w_pf <= 1'h1;
      settle();
      apb(1'h0, LCS_ADDR, 32'h0);
      chk(q, RDY | ATN | ERF, "pf attention_flag");
      chk(32'(host_irq), 32'h0, "pf masked");
      apb(1'h1, MASK_ADDR, 32'h7);
      repeat (2) @(posedge mclk);
      chk(32'(host_irq), 32'h1, "pf unmasked");
      w_pf <= 1'h0;
      apb(1'h1, STS_ADDR, 32'h4);
      apb(1'h1, LCS_ADDR, 32'h0);
      apb(1'h0, LCS_ADDR, 32'h0);
      chk(q, RDY, "pf cleared");
      chk(32'(host_irq), 32'h0, "pf irq off");
      attention_request <= 1'h1;
      settle();
      apb(1'h0, LCS_ADDR, 32'h0);
      chk(q, RDY | ATN | ERF, "local attention_flag");
      attention_request <= 1'h0;
      apb(1'h1, LCS_ADDR, 32'h0);
      apb(1'h1, STS_ADDR, 32'h7);
      $display("test pf done");
   endtask : t_pf
   // outputs toward the companion, same-type and mixed link
   task automatic t_out;
      apb(1'h1, LCS_ADDR, 32'h0);
      repeat (2) @(posedge mclk);
      chk(32'({hold_seen, bsel_o}), 32'h2, "burst hold");
      apb(1'h1, LCS_ADDR, 32'h000e);
      repeat (2) @(posedge mclk);
      chk(32'({cyc_o, far_o, bsel_o, hold_o}), 32'he, "outs");
      apb(1'h1, CFG_ADDR, 32'h1);
      mixed <= 1'h1;
      settle();
      chk(32'({bsel_o, hold_o}), 32'h0, "mixed outs");
      apb(1'h0, LCS_ADDR, 32'h0);
      chk(q, RDY | STA | 32'h000e, "mixed bit 11");
      mixed <= 1'h0;
      apb(1'h1, CFG_ADDR, 32'h0);
      // clearing select again must bring the hold line back
      apb(1'h1, LCS_ADDR, 32'h0);
      repeat (2) @(posedge mclk);
      chk(32'({hold_seen, hold_o}), 32'h3, "hold back");
      $display("test out done");
   endtask : t_out
   // initialization clears flags, storage and status once causes are gone
   task automatic t_init;
      apb(1'h1, LCS_ADDR, 32'h0040);
      attention_request <= 1'h1;
      settle();
      attention_request <= 1'h0;
      settle();
      apb(1'h0, LCS_ADDR, 32'h0);
      chk(q, IEN | RDY | ATN | ERF, "attention_flag before init");
      chk(32'(host_irq), 32'h1, "attention_flag irq");
      reset_n <= 1'h0;
      repeat (2) @(posedge mclk);
      reset_n <= 1'h1;
      @(posedge mclk);
      apb(1'h0, LCS_ADDR, 32'h0);
      chk(q, RDY, "init clears");
      chk(32'(host_irq), 32'h0, "init irq off");
      $display("test init done");
   endtask : t_init
   ////////////////////////////////////////////////////////////////////////
   // clock, 50 ns period
   initial begin
      mclk = 1'h0;
      forever #25 mclk = ~mclk;
   end
   // hang guard, far above the few hundred cycles needed
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         n_fail++;
         $display("ERROR %0t timeout", $time);
         results();
      end
   end
   // main sequence
   initial begin
      {reset_n, psel, penable, pwrite, paddr, pwdata} = '0;
      {w_cyc, w_far, w_burst, w_pf, mixed, attention_request} = '0;
      {n_fail, checks, cycles} = '0;
      repeat (8) @(posedge mclk);
      reset_n <= 1'h1;
      @(posedge mclk);
      t_reset();
      t_mirror();
      t_far();
      t_pf();
      t_out();
      t_init();
      results();
   end
endmodule : link_status_attention_bits_test
